// ### design/stcr_defs.vh
// Purpose: Constants for the transceiver channel control register bank
// Assumes: 8 channels, 7-bit registers, 3-bit register address
// Notes:   Field positions and reset values of each channel register
`ifndef STCR_DEFS_VH
`define STCR_DEFS_VH

`define STCR_NUM_CH         8
`define STCR_ADDR_W         3
`define STCR_DATA_W         7
`define STCR_BIT_CNT_W      3

`define STCR_CH0_OFFSET     3'h0
`define STCR_CH1_OFFSET     3'h1
`define STCR_CH2_OFFSET     3'h2
`define STCR_CH3_OFFSET     3'h3
`define STCR_CH4_OFFSET     3'h4
`define STCR_CH5_OFFSET     3'h5
`define STCR_CH6_OFFSET     3'h6
`define STCR_CH7_OFFSET     3'h7

`define STCR_DRIVER_SHUTDOWN_POS    6
`define STCR_SLEW_LIMIT_POS         5
`define STCR_TX_TERM_POS            4
`define STCR_RX_TERM_POS            3
`define STCR_ECHO_INHIBIT_POS       2
`define STCR_HALF_DUPLEX_POS        1
`define STCR_LINE_STANDARD_POS      0

`define STCR_CTRL_RESET     7'h40

`define STCR_LAST_BIT       3'h6

`endif

// ### design/stcr_sync.v
// Purpose: Two-flop synchroniser for a group of asynchronous levels
// Assumes: Inputs come from pins outside the clk domain
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module stcr_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk,
    input  wire             reset_n,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_reg <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule // stcr_sync

// ### design/stcr_channel_reg.v
// Purpose: One 7-bit channel control register with its decoded outputs
// Assumes: Write strobe is a one-cycle pulse on clk
// Notes:   Outputs come straight from the register flops
`timescale 1ns/1ps
`include "stcr_defs.vh"
module stcr_channel_reg (
    input  wire       clk,
    input  wire       reset_n,
    input  wire       wr_strobe,
    input  wire [6:0] wr_value,
    output wire [6:0] value,
    output wire       driver_shutdown,
    output wire       slew_limit,
    output wire       tx_line_termination,
    output wire       rx_line_termination,
    output wire       echo_inhibit,
    output wire       half_duplex_select,
    output wire       line_standard_select
);
    reg [6:0] ctrl_reg;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= `STCR_CTRL_RESET;
        end else if (wr_strobe) begin
            ctrl_reg <= wr_value;
        end
    end

    assign value                = ctrl_reg;
    assign driver_shutdown      = ctrl_reg[`STCR_DRIVER_SHUTDOWN_POS];
    assign slew_limit           = ctrl_reg[`STCR_SLEW_LIMIT_POS];
    assign tx_line_termination  = ctrl_reg[`STCR_TX_TERM_POS];
    assign rx_line_termination  = ctrl_reg[`STCR_RX_TERM_POS];
    assign echo_inhibit         = ctrl_reg[`STCR_ECHO_INHIBIT_POS];
    assign half_duplex_select   = ctrl_reg[`STCR_HALF_DUPLEX_POS];
    assign line_standard_select = ctrl_reg[`STCR_LINE_STANDARD_POS];
endmodule // stcr_channel_reg

// ### design/stcr_config_regs.v
// Purpose: Serial transceiver configuration register bank behind a pin bus
// Assumes: clk much faster than the bus clock pin; all bus pins are async
// Notes:   Bus pins are synchronised, then bus clock edges are detected
`timescale 1ns/1ps
`include "stcr_defs.vh"
module stcr_config_regs #(
    parameter NUM_CH = `STCR_NUM_CH
) (
    input  wire                clk,
    input  wire                reset_n,
    input  wire                bus_chip_enable,
    input  wire                bus_read_not_write,
    input  wire                bus_clk,
    input  wire [2:0]          bus_addr,
    input  wire                bus_serial_wdata,
    output wire                bus_serial_rdata,
    output wire [NUM_CH-1:0]   driver_shutdown,
    output wire [NUM_CH-1:0]   slew_limit,
    output wire [NUM_CH-1:0]   tx_line_termination,
    output wire [NUM_CH-1:0]   rx_line_termination,
    output wire [NUM_CH-1:0]   echo_inhibit,
    output wire [NUM_CH-1:0]   half_duplex_select,
    output wire [NUM_CH-1:0]   line_standard_select
);
    localparam ST_IDLE  = 4'b0001;
    localparam ST_ARMED = 4'b0010;
    localparam ST_WRITE = 4'b0100;
    localparam ST_READ  = 4'b1000;

    wire [6:0] pins_sync;
    wire       cen_s;
    wire       rnw_s;
    wire       bclk_s;
    wire [2:0] addr_s;
    wire       wdata_s;

    reg  [3:0] state_reg;
    reg  [3:0] state_next;
    reg        bclk_d_reg;
    reg  [2:0] addr_reg;
    reg  [2:0] addr_next;
    reg  [6:0] shift_reg;
    reg  [6:0] shift_next;
    reg  [2:0] count_reg;
    reg  [2:0] count_next;
    reg        dirty_reg;
    reg        dirty_next;
    reg        rdata_reg;
    reg        rdata_next;
    reg        commit;
    reg  [6:0] rd_value;

    wire [NUM_CH*7-1:0] all_values;
    wire                bclk_rise;

    // Pins from the bridge are asynchronous to clk
    stcr_sync #(
        .WIDTH (7)
    ) u_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in ({bus_serial_wdata, bus_addr, bus_clk, bus_read_not_write,
                    bus_chip_enable}),
        .sync_out (pins_sync)
    );

    assign cen_s   = pins_sync[0];
    assign rnw_s   = pins_sync[1];
    assign bclk_s  = pins_sync[2];
    assign addr_s  = pins_sync[5:3];
    assign wdata_s = pins_sync[6];

    // Edge found on the synchronised copy, never on the first stage
    assign bclk_rise = bclk_s & ~bclk_d_reg;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg  <= ST_IDLE;
            bclk_d_reg <= 1'b0;
            addr_reg   <= 3'h0;
            shift_reg  <= 7'h00;
            count_reg  <= 3'h0;
            dirty_reg  <= 1'b0;
            rdata_reg  <= 1'b0;
        end else begin
            state_reg  <= state_next;
            bclk_d_reg <= bclk_s;
            addr_reg   <= addr_next;
            shift_reg  <= shift_next;
            count_reg  <= count_next;
            dirty_reg  <= dirty_next;
            rdata_reg  <= rdata_next;
        end
    end

    // Read mux over the channel values
    always @* begin
        rd_value = all_values[7*addr_s +: 7];
    end

    always @* begin
        state_next = state_reg;
        addr_next  = addr_reg;
        shift_next = shift_reg;
        count_next = count_reg;
        dirty_next = dirty_reg;
        rdata_next = rdata_reg;
        commit     = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                rdata_next = 1'b0;
                if (cen_s) begin
                    state_next = ST_ARMED;
                    count_next = 3'h0;
                    dirty_next = 1'b0;
                end
            end
            ST_ARMED: begin
                if (!cen_s) begin
                    state_next = ST_IDLE;
                end else if (bclk_rise) begin
                    addr_next  = addr_s;
                    count_next = 3'h1;
                    if (rnw_s) begin
                        state_next = ST_READ;
                        shift_next = {rd_value[5:0], 1'b0};
                        rdata_next = rd_value[6];
                    end else begin
                        state_next = ST_WRITE;
                        shift_next = {6'h00, wdata_s};
                        dirty_next = 1'b1;
                    end
                end
            end
            ST_WRITE: begin
                if (!cen_s) begin
                    // A cut write commits its bits right-aligned, upper bits zero
                    commit     = dirty_reg;
                    state_next = ST_IDLE;
                end else if (bclk_rise && count_reg <= `STCR_LAST_BIT) begin
                    // Later edges fall through and are ignored
                    shift_next = {shift_reg[5:0], wdata_s};
                    count_next = count_reg + 3'h1;
                end
            end
            ST_READ: begin
                if (!cen_s) begin
                    state_next = ST_IDLE;
                end else if (bclk_rise && count_reg <= `STCR_LAST_BIT) begin
                    rdata_next = shift_reg[6];
                    shift_next = {shift_reg[5:0], 1'b0};
                    count_next = count_reg + 3'h1;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Held low outside a read so the host never takes a stale bit
    assign bus_serial_rdata = rdata_reg;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_ch
            stcr_channel_reg u_reg (
                .clk                  (clk),
                .reset_n              (reset_n),
                .wr_strobe            (commit && (addr_reg == ch)),
                .wr_value             (shift_reg),
                .value                (all_values[7*ch +: 7]),
                .driver_shutdown      (driver_shutdown[ch]),
                .slew_limit           (slew_limit[ch]),
                .tx_line_termination  (tx_line_termination[ch]),
                .rx_line_termination  (rx_line_termination[ch]),
                .echo_inhibit         (echo_inhibit[ch]),
                .half_duplex_select   (half_duplex_select[ch]),
                .line_standard_select (line_standard_select[ch])
            );
        end
    endgenerate
endmodule // stcr_config_regs

// ### dv/stcr_config_regs_asserts.sv
// Purpose: Port checks for the channel register bank
// Assumes: Host keeps the bench pin timing
// Notes:   Windows allow for pin synchroniser delay
`timescale 1ns/1ps
module stcr_config_regs_asserts #(parameter NUM_CH = 8) (
    input wire              clk,
    input wire              reset_n,
    input wire              bus_chip_enable,
    input wire              bus_read_not_write,
    input wire              bus_clk,
    input wire [2:0]        bus_addr,
    input wire              bus_serial_wdata,
    input wire              bus_serial_rdata,
    input wire [NUM_CH-1:0] driver_shutdown,
    input wire [NUM_CH-1:0] slew_limit,
    input wire [NUM_CH-1:0] tx_line_termination,
    input wire [NUM_CH-1:0] rx_line_termination,
    input wire [NUM_CH-1:0] echo_inhibit,
    input wire [NUM_CH-1:0] half_duplex_select,
    input wire [NUM_CH-1:0] line_standard_select
);
    wire [NUM_CH-1:0]   lo = slew_limit | tx_line_termination | rx_line_termination
        | echo_inhibit | half_duplex_select | line_standard_select;
    wire [8*NUM_CH-1:0] cfg = {driver_shutdown, lo, tx_line_termination, rx_line_termination,
        echo_inhibit, half_duplex_select, line_standard_select, slew_limit};
    default clocking dc @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_RST_DRIVER_SHUTDOWN: assert property ($rose(reset_n) |-> &driver_shutdown)
        else $error("shutdown low after reset");
    AST_RST_LOW: assert property ($rose(reset_n) |-> lo == '0)
        else $error("control bit high after reset");
    // Sync delay varies, so the commit is placed in a window after the enable falls
    AST_CFG_AFTER_CEN: assert property (
        !$stable(cfg) |-> $past(bus_chip_enable, 6) && !$past(bus_chip_enable, 3))
        else $error("outputs moved outside a commit");
    AST_CFG_WRITE_ONLY: assert property (
        !$stable(cfg) |-> !$past(bus_read_not_write, 6))
        else $error("outputs moved after a read");
    // Every field is compared, so a commit cannot hide a change in a second channel
    AST_ONE_CHANNEL: assert property (
        !$stable(cfg) |-> $onehot0(($past(driver_shutdown) ^ driver_shutdown)
            | ($past(slew_limit) ^ slew_limit)
            | ($past(tx_line_termination) ^ tx_line_termination)
            | ($past(rx_line_termination) ^ rx_line_termination)
            | ($past(echo_inhibit) ^ echo_inhibit)
            | ($past(half_duplex_select) ^ half_duplex_select)
            | ($past(line_standard_select) ^ line_standard_select)))
        else $error("commit touched two channels");
    AST_CFG_SETTLES: assert property (!$stable(cfg) |=> $stable(cfg) [*3])
        else $error("outputs moved twice");
    AST_RD_IDLE: assert property (!bus_chip_enable [*6] |-> !bus_serial_rdata)
        else $error("read data high while idle");
    AST_RD_ON_RISE: assert property (
        bus_chip_enable && $changed(bus_serial_rdata) |-> $past(bus_clk, 3))
        else $error("read data moved without a clock rise");
endmodule // stcr_config_regs_asserts
bind stcr_config_regs stcr_config_regs_asserts #(.NUM_CH(NUM_CH)) u_chk (.clk, .reset_n,
    .bus_chip_enable, .bus_read_not_write, .bus_clk, .bus_addr, .bus_serial_wdata,
    .bus_serial_rdata, .driver_shutdown, .slew_limit, .tx_line_termination,
    .rx_line_termination, .echo_inhibit, .half_duplex_select, .line_standard_select);

// ### dv/stcr_host_model.sv
// Purpose: Host that bit-bangs the pin bus
// Assumes: Eight clk cycles per bus clock period
// Notes:   Released data line toggles so stale bits never pass
`timescale 1ns/1ps
module stcr_host_model (
    input  wire        clk,
    input  wire        bus_serial_rdata,
    output logic       bus_chip_enable,
    output logic       bus_read_not_write,
    output logic       bus_clk,
    output logic [2:0] bus_addr,
    output logic       bus_serial_wdata,
    output logic       rd_done,
    output logic [6:0] rd_val
);
    // Pins 6..0 only driven, pin 7 only sampled
    initial begin
        {bus_chip_enable, bus_read_not_write, bus_clk, bus_addr, bus_serial_wdata} = 7'h00;
        {rd_done, rd_val} = 8'h00;
    end
    // A rising bus clock edge moves bus_clk alone; a falling edge also moves address and data
    task automatic xfer(input logic rnw, input logic [2:0] a, input logic [6:0] d, input int n);
        logic [6:0] q;
        q = 7'h00;
        bus_chip_enable <= 1'b1;
        bus_read_not_write <= rnw;
        bus_addr <= a;
        bus_serial_wdata <= rnw ? ~bus_serial_wdata : d[6];
        repeat (4) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            bus_clk <= 1'b1;
            repeat (4) @(posedge clk);
            bus_clk <= 1'b0;
            bus_addr <= ~a;
            bus_serial_wdata <= (!rnw && i < 6) ? d[5-i] : ~bus_serial_wdata;
            repeat (3) @(posedge clk);
            @(negedge clk);
            if (i < 7)
                q[6-i] = bus_serial_rdata;
            @(posedge clk);
        end
        bus_chip_enable <= 1'b0;
        rd_val <= q;
        rd_done <= rnw;
        @(posedge clk);
        rd_done <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
endmodule // stcr_host_model

// ### dv/stcr_config_regs_tb_top.sv
// Purpose: Self-checking bench for the channel register bank
// Assumes: Host model drives the bus pins on clk rising edges
// Notes:   Expected values come from a shadow copy of the registers
`timescale 1ns/1ps
module stcr_config_regs_tb_top;
    logic        clk, reset_n, bus_chip_enable, bus_read_not_write, bus_clk;
    logic        bus_serial_wdata, bus_serial_rdata, rd_done;
    logic [2:0]  bus_addr;
    logic [6:0]  rd_val, v, mem [8], exp_q [$];
    logic [7:0]  driver_shutdown, slew_limit, tx_line_termination, rx_line_termination;
    logic [7:0]  echo_inhibit, half_duplex_select, line_standard_select;
    logic [31:0] rnd;
    int          n_fail = 0, n_tests = 0, cyc = 0;
    integer      seed = 32'h8dd3;
    stcr_config_regs dut (.clk, .reset_n, .bus_chip_enable, .bus_read_not_write, .bus_clk,
        .bus_addr, .bus_serial_wdata, .bus_serial_rdata, .driver_shutdown, .slew_limit,
        .tx_line_termination, .rx_line_termination, .echo_inhibit, .half_duplex_select,
        .line_standard_select);
    stcr_host_model host (.clk, .bus_serial_rdata, .bus_chip_enable, .bus_read_not_write,
        .bus_clk, .bus_addr, .bus_serial_wdata, .rd_done, .rd_val);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task check(input logic [6:0] seen, input logic [6:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task chk_all();
        for (int c = 0; c < 8; c++) begin
            v = {driver_shutdown[c], slew_limit[c], tx_line_termination[c],
                rx_line_termination[c], echo_inhibit[c], half_duplex_select[c],
                line_standard_select[c]};
            check(v, mem[c]);
        end
    endtask
    task wr(input int a, input logic [6:0] d, input int n);
        host.xfer(1'b0, a[2:0], d, n);
        if (n >= 7)
            mem[a] = d;
        else if (n > 0)
            mem[a] = d >> (7 - n);
    endtask
    task rd(input int a, input int n);
        exp_q.push_back(mem[a]);
        host.xfer(1'b1, a[2:0], 7'h00, n);
    endtask
    // Each read result is matched with the note taken when it was issued
    always @(posedge clk)
        if (rd_done === 1'b1)
            check(rd_val, exp_q.pop_front());
    // About 30 transfers of 70 cycles each; the ceiling leaves wide margin
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        reset_n = 1'b0;
        for (int c = 0; c < 8; c++)
            mem[c] = 7'h40;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk_all();
        for (int c = 0; c < 8; c++)
            rd(c, 7);
        for (int c = 0; c < 8; c++) begin
            rnd = $random(seed);
            wr(c, rnd[6:0], 7);
        end
        wr(3, 7'h7F, 9);
        wr(5, 7'h00, 7);
        wr(6, 7'h2A, 0);
        wr(4, 7'h55, 3);
        chk_all();
        rd(3, 9);
        for (int c = 0; c < 8; c++)
            rd(c, 7);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        for (int c = 0; c < 8; c++)
            mem[c] = 7'h40;
        repeat (4) @(posedge clk);
        chk_all();
        rd(2, 7);
        repeat (4) @(posedge clk);
        if (exp_q.size() != 0)
            n_fail++;
        report_and_stop();
    end
endmodule // stcr_config_regs_tb_top
